// ---- bench/accum_chk_sva.sv ----
`timescale 1ns/100ps
module accum_chk #(
    parameter CONV_CYCLES = 400
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [15:0] raw_current,
    input logic [7:0] temp_deg,
    input logic [15:0] nv_accum_offset,
    input logic conv_strobe,
    input logic [15:0] current_result,
    input logic [15:0] charge_accumulator,
    input logic [15:0] full_capacity,
    input logic [15:0] active_empty_capacity,
    input logic [15:0] standby_empty_capacity
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    int gap_r;
    logic seen_r;
    // Cycles since the last conversion pulse; the first pulse has no predecessor
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= conv_strobe ? 0 : gap_r + 1;
            seen_r <= seen_r | conv_strobe;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_ready_next;
        s_setup |=> s_access;
    endproperty
    property p_ready_cause;
        pready |-> $past(psel && !penable);
    endproperty
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    property p_strobe_period;
        conv_strobe && seen_r |-> gap_r == CONV_CYCLES - 1;
    endproperty
    property p_strobe_pulse;
        conv_strobe |=> !conv_strobe [*8];
    endproperty
    property p_result_src;
        $changed(current_result) |-> $past(conv_strobe);
    endproperty
    property p_acr_src;
        $changed(charge_accumulator) |->
            $past(conv_strobe) || $past(psel && penable && pwrite && paddr == 12'h18c);
    endproperty
    property p_standby_nonpos;
        !($signed(standby_empty_capacity) > 0);
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no access after setup");
    a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
    a_err_zero: assert property (p_err_zero) else $error("error data not zero");
    a_strobe_period: assert property (p_strobe_period) else $error("bad period");
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    a_result_src: assert property (p_result_src) else $error("result moved");
    a_acr_src: assert property (p_acr_src) else $error("accumulator moved");
    a_standby_nonpos: assert property (p_standby_nonpos) else $error("standby above 0");
endmodule // accum_chk

bind accum_bias_blank_cell_model accum_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

// ---- bench/apb_host.sv ----
`timescale 1ns/100ps
// Host side; the empty limits are chosen offline, nothing to drive here
module apb_host (
    input wire pclk,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [11:0] paddr,
    output reg [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // One transfer, called just after a rising edge; the request stands until
    // pready is seen high at a rising edge, and data is taken at that edge
    task xfer(input [7:0] idx, input w, input [31:0] d, output [31:0] q, output e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-raises psel in this time step
        @(posedge pclk);
    endtask
endmodule // apb_host

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [15:0] raw_current = 16'h0;
    logic [7:0] temp_deg = 8'h32;
    logic [15:0] nv_accum_offset = 16'h1234;
    wire psel, penable, pwrite, pready, pslverr, conv_strobe;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [15:0] current_result, charge_accumulator, full_capacity;
    wire [15:0] active_empty_capacity, standby_empty_capacity;
    logic [31:0] q;
    logic e;
    int mismatches = 0;
    int cmp_count = 0;
    always #2.5 pclk = ~pclk;
    accum_bias_blank_cell_model #(.CONV_CYCLES(400)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_current(raw_current),
        .temp_deg(temp_deg), .nv_accum_offset(nv_accum_offset), .conv_strobe(conv_strobe),
        .current_result(current_result), .charge_accumulator(charge_accumulator),
        .full_capacity(full_capacity), .active_empty_capacity(active_empty_capacity),
        .standby_empty_capacity(standby_empty_capacity));
    apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] idx, input [31:0] d);
        host.xfer(idx, 1'b1, d, q, e);
    endtask
    task rd(input [7:0] idx, input [31:0] exp);
        host.xfer(idx, 1'b0, 32'h0, q, e);
        chk(q, exp);
    endtask
    // Raw value stands from a rising edge; the strobe is judged at the edge
    // that uses it, and outputs are read one edge later when settled
    task conv(input [15:0] r);
        raw_current <= r;
        @(posedge pclk);
        while (!conv_strobe) @(posedge pclk);
        @(posedge pclk);
    endtask
    // Current LSB is one accumulator fraction LSB, so the visible word moves
    // only by whole carries; x presets the word with a cleared fraction
    task step(input [7:0] c, input n, input [15:0] r, input [15:0] x, input [15:0] a);
        wr(8'h61, {24'h0, c});
        wr(8'h60, {31'h0, n});
        wr(8'h63, {16'h0, x});
        conv(r);
        chk(current_result, {16'h0, r + {{8{c[7]}}, c}});
        chk(charge_accumulator, a);
    endtask
    task t_reset;
        rd(8'h62, 32'h1234);
        rd(8'h60, 32'h0);
        rd(8'h10, 32'h0);
        chk(e, 1'b1);
        $display("reset test done");
    endtask
    // A bias of minus 64 counts makes a charge blank visible as one borrow
    task t_blank;
        wr(8'h62, 32'hffc0);
        step(8'h00, 1'b0, 16'h003f, 16'h0100, 16'h00ff);
        step(8'h00, 1'b0, 16'h0040, 16'h0100, 16'h0100);
        step(8'h04, 1'b0, 16'h003c, 16'h0100, 16'h0100);
        wr(8'h62, 32'h0);
        step(8'h00, 1'b0, 16'hfff1, 16'h0100, 16'h00ff);
        step(8'h00, 1'b1, 16'hfff1, 16'h0100, 16'h0100);
        step(8'h00, 1'b1, 16'hfff0, 16'h0100, 16'h00ff);
        $display("blanking test done");
    endtask
    // A bias of 4096 counts is one whole step of the visible word
    task t_bias;
        wr(8'h62, 32'h1000);
        step(8'h00, 1'b0, 16'h0000, 16'h0100, 16'h0101);
        wr(8'h62, 32'hf000);
        step(8'h00, 1'b0, 16'h0000, 16'h0100, 16'h00ff);
        wr(8'h62, 32'h0);
        step(8'h00, 1'b0, 16'h7fff, 16'h7fff, 16'h7fff);
        step(8'h00, 1'b0, 16'h8000, 16'h8000, 16'h8000);
        $display("bias test done");
    endtask
    // Flat above the top point, then seg 4 for one degree and seg 3 below the high point
    task t_curve;
        wr(8'h68, 32'h3e8);
        wr(8'h69, 32'h80);
        wr(8'h6e, 32'h80);
        wr(8'h6d, 32'h40);
        wr(8'h7c, 32'hf4);
        wr(8'h7d, 32'h0);
        wr(8'h7e, 32'h27);
        rd(8'h7c, 32'hf4);
        rd(8'h7e, 32'h27);
        rd(8'h6d, 32'h40);
        conv(16'h0);
        repeat (4) @(posedge pclk);
        chk(full_capacity, 16'h03e8);
        chk(active_empty_capacity, 16'h01f4);
        chk(standby_empty_capacity, 16'h0);
        temp_deg <= 8'h26;
        conv(16'h0);
        repeat (6) @(posedge pclk);
        chk(full_capacity, 16'h03dc);
        chk(active_empty_capacity, 16'h01f4);
        $display("curve test done");
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_blank();
        t_bias();
        t_curve();
        stop_test();
    end
    // Twelve conversions of 400 cycles fit easily in this span
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
endmodule // tb

// ---- src/accum_bias_blank_cell_model.v ----
// What this block does
// [R1] Add accumulation offset once per conversion
// [R2] Load accumulation offset from nonvolatile at power-up
// [R3] Blank on raw plus trim, skip accumulation
// [R4] Charge results below 100 uV always blanked
// [R5] Discharge below 25 uV blanked when enabled
// [R6] Three curves, five segments each; the code slopes only four per curve and holds the value flat above 40 C
// [R7] Above 40 C value is held flat
// [R8] Segments bounded by 40 C and breakpoints
// [R9] Breakpoints signed bytes, one degree steps
// [R10] Low, mid, high breakpoints consecutive
// [R11] Slope counts of 61 ppm, unsigned
// [R12] Rebuild curves in one-degree steps
// [R13] Normalised to full at 40 C
// [R14] Stored full at 40 C and empty fraction
// [R15] Standby empty at 40 C is zero
// [R16] Host picks empty limits as averages
// [R17] No standby current or voltage held
// [R18] Trimmed current reported and accumulated
// [R19] Accumulator saturates, never wraps
// [R20] New current result every 3.515 s
// [R21] Step down subtracting slope times nominal
// [R22] Offset added after blanking
`timescale 1ns/100ps
`include "accum_model_defs.vh"

module accum_bias_blank_cell_model #(
    parameter CONV_CYCLES = `CONV_PERIOD_US * `CLK_MHZ
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] raw_current,
    input wire [7:0] temp_deg,
    input wire [15:0] nv_accum_offset,
    output reg conv_strobe,
    output reg [15:0] current_result,
    output reg [15:0] charge_accumulator,
    output reg [15:0] full_capacity,
    output reg [15:0] active_empty_capacity,
    output reg [15:0] standby_empty_capacity
);

    localparam [31:0] CONV_LAST = CONV_CYCLES - 1;

    // Saturate a 17-bit signed sum to 16 bits
    function [15:0] sat16;
        input [16:0] v;
        begin
            if (v[16] != v[15]) begin
                sat16 = v[16] ? 16'h8000 : 16'h7fff;
            end else begin
                sat16 = v[15:0];
            end
        end
    endfunction

    // Take a model value with fraction bits back to 16-bit signed
    function [15:0] model_out;
        input [31:0] v;
        reg [31:0] s;
        begin
            s = $signed(v) >>> `SLOPE_SHIFT;
            if (s[31] && (s[30:15] != 16'hffff)) begin
                model_out = 16'h8000;
            end else if (!s[31] && (s[30:15] != 16'h0000)) begin
                model_out = 16'h7fff;
            end else begin
                model_out = s[15:0];
            end
        end
    endfunction

    // One degree step: nominal times slope count, 61 ppm is 2^-14
    function [31:0] step_down;
        input [31:0] v;
        input [15:0] nominal;
        input [7:0] slope;
        begin
            // Both factors widened first so the product keeps all 24 bits
            step_down = v - {8'h00, {8'h00, nominal} * {16'h0000, slope}}; // [R21] [R11]
        end
    endfunction

    // Segment (0..3 for 1..4) that spans the step from t down to t-1
    function [1:0] seg_of;
        input [8:0] t;
        input [7:0] lo;
        input [7:0] mid;
        input [7:0] hi;
        begin
            if ($signed(t) > $signed({hi[7], hi})) begin
                seg_of = 2'd3; // [R8]
            end else if ($signed(t) > $signed({mid[7], mid})) begin
                seg_of = 2'd2;
            end else if ($signed(t) > $signed({lo[7], lo})) begin
                seg_of = 2'd1;
            end else begin
                seg_of = 2'd0; // [R8] segment 1 runs on to any cold temperature
            end
        end
    endfunction

    // Host settings
    reg neg_blank_en_r;
    reg [7:0] trim_ofs_r;
    reg [15:0] accum_ofs_r;

    // Accumulator with its hidden fraction bits below the visible word
    reg [`ACCUM_W-1:0] accum_r;

    // Cell model parameters
    reg [15:0] full40_r;
    reg [7:0] ae_frac_r;
    reg [7:0] slope_r [0:`NUM_SLOPES-1];
    reg [7:0] bp_low_r;
    reg [7:0] bp_mid_r;
    reg [7:0] bp_high_r;

    // Timebase and rebuild state
    reg load_done_r;
    reg [31:0] conv_cnt_r;
    reg [1:0] state_r;
    reg [8:0] step_temp_r;
    reg [8:0] target_r;
    reg [31:0] full_v_r;
    reg [31:0] ae_v_r;
    reg [31:0] se_v_r;
    reg start_r;

    // Address decode; only the first word-aligned kilobyte is mapped
    wire [7:0] idx = paddr[9:2];
    wire idx_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    wire in_slopes = (idx >= `IDX_SLOPE_FIRST) && (idx <= `IDX_SLOPE_LAST);
    wire [7:0] slope_ofs = idx - `IDX_SLOPE_FIRST;
    // Low bits suffice; indexes outside the slope range are gated by in_slopes
    wire [`SLOPE_IDX_W-1:0] slope_sel = slope_ofs[`SLOPE_IDX_W-1:0];
    // A write lands only at the access edge, and never on an error
    wire wr_en = psel && penable && pready && pwrite && !pslverr;

    // Trimmed current, blanking and the per-conversion delta
    wire [15:0] trim = sat16({raw_current[15], raw_current} +
        {{9{trim_ofs_r[7]}}, trim_ofs_r}); // [R18] [R3]
    // Zero falls in the charge window; blanking it changes nothing
    wire blank_chg = !trim[15] && (trim < `CHG_BLANK_LIMIT); // [R4]
    wire blank_dis = neg_blank_en_r && trim[15] &&
        ($signed(trim) > -$signed(`DIS_BLANK_LIMIT)); // [R5]
    wire [15:0] acc_in = (blank_chg || blank_dis) ? 16'h0000 : trim; // [R3]
    // Bias still goes in when the current itself was blanked
    wire [16:0] delta = {acc_in[15], acc_in} +
        {accum_ofs_r[15], accum_ofs_r}; // [R22] [R1]
    // Current LSB equals one accumulator fraction LSB, so delta adds at bit 0;
    // small currents only show in the visible word once the fraction carries
    wire [`ACCUM_W:0] accum_sum = {accum_r[`ACCUM_W-1], accum_r} +
        {{(`ACCUM_W-16){delta[16]}}, delta};
    // Clamp instead of wrapping, so a long charge cannot read as empty
    wire [`ACCUM_W-1:0] accum_sat = (accum_sum[`ACCUM_W] != accum_sum[`ACCUM_W-1]) ?
        (accum_sum[`ACCUM_W] ? `ACCUM_MIN : `ACCUM_MAX) :
        accum_sum[`ACCUM_W-1:0]; // [R19]

    // Active empty start value; factors widened so no product bit is lost
    wire [23:0] ae_start = {8'h00, full40_r} * {16'h0000, ae_frac_r}; // [R14]

    // Read mux; unmapped indexes answer zero with an error
    reg [31:0] rd_data;
    reg rd_err;
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (!idx_ok) begin
            rd_err = 1'b1;
        end else if (in_slopes) begin
            rd_data = {24'h000000, slope_r[slope_sel]};
        end else begin
            case (idx)
                `IDX_CONTROL: rd_data = {31'h00000000, neg_blank_en_r};
                `IDX_TRIM: rd_data = {24'h000000, trim_ofs_r};
                `IDX_ACCUM_OFS: rd_data = {16'h0000, accum_ofs_r};
                `IDX_ACCUM: rd_data = {16'h0000, accum_r[`ACCUM_W-1:`ACCUM_FRAC_W]};
                `IDX_CURRENT: rd_data = {16'h0000, current_result};
                `IDX_FULL_CAP: rd_data = {16'h0000, full_capacity};
                `IDX_AE_CAP: rd_data = {16'h0000, active_empty_capacity};
                `IDX_SE_CAP: rd_data = {16'h0000, standby_empty_capacity};
                `IDX_FULL40: rd_data = {16'h0000, full40_r};
                `IDX_AE_FRAC: rd_data = {24'h000000, ae_frac_r};
                `IDX_BP_LOW: rd_data = {24'h000000, bp_low_r};
                `IDX_BP_MID: rd_data = {24'h000000, bp_mid_r};
                `IDX_BP_HIGH: rd_data = {24'h000000, bp_high_r};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // APB answer: data and error are set up in the setup cycle, so the
    // access phase always ends on its first edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr <= rd_err;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Conversion timebase divider
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cnt_r <= 32'h0000_0000;
            conv_strobe <= 1'b0;
        end else begin
            conv_strobe <= (conv_cnt_r == CONV_LAST); // [R20]
            if (conv_cnt_r == CONV_LAST) begin
                conv_cnt_r <= 32'h0000_0000;
            end else begin
                conv_cnt_r <= conv_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Host-writable settings; the offset is caught once after reset
    integer i;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_blank_en_r <= 1'b0;
            trim_ofs_r <= 8'h00;
            accum_ofs_r <= 16'h0000;
            full40_r <= 16'h0000;
            ae_frac_r <= 8'h00;
            bp_low_r <= 8'h00;
            bp_mid_r <= 8'h00;
            bp_high_r <= 8'h00;
            load_done_r <= 1'b0;
            for (i = 0; i < `NUM_SLOPES; i = i + 1) begin
                slope_r[i] <= 8'h00;
            end
        end else begin
            if (!load_done_r) begin
                accum_ofs_r <= nv_accum_offset; // [R2]
                load_done_r <= 1'b1;
            end else if (wr_en && idx == `IDX_ACCUM_OFS) begin
                accum_ofs_r <= pwdata[15:0];
            end
            if (wr_en) begin
                if (in_slopes) begin
                    slope_r[slope_sel] <= pwdata[7:0]; // [R11] [R13]
                end
                case (idx)
                    `IDX_CONTROL: neg_blank_en_r <= pwdata[`CTRL_NEG_BLANK_BIT]; // [R5]
                    `IDX_TRIM: trim_ofs_r <= pwdata[7:0];
                    `IDX_FULL40: full40_r <= pwdata[15:0]; // [R14]
                    `IDX_AE_FRAC: ae_frac_r <= pwdata[7:0]; // [R14]
                    `IDX_BP_LOW: bp_low_r <= pwdata[7:0]; // [R9] [R10]
                    `IDX_BP_MID: bp_mid_r <= pwdata[7:0]; // [R10]
                    `IDX_BP_HIGH: bp_high_r <= pwdata[7:0]; // [R10]
                    default: ;
                endcase
            end
        end
    end

    // Current result and accumulation; a host write to the accumulator
    // overrides that cycle's accumulation and clears the fraction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_r <= {`ACCUM_W{1'b0}};
            current_result <= 16'h0000;
            charge_accumulator <= 16'h0000;
        end else begin
            if (wr_en && idx == `IDX_ACCUM) begin
                accum_r <= {pwdata[15:0], {`ACCUM_FRAC_W{1'b0}}};
                charge_accumulator <= pwdata[15:0];
            end else if (conv_strobe) begin
                accum_r <= accum_sat; // [R1] [R19]
                charge_accumulator <= accum_sat[`ACCUM_W-1:`ACCUM_FRAC_W];
            end
            if (conv_strobe) begin
                current_result <= trim; // [R18] [R20]
            end
        end
    end

    // Curve rebuild: start at 40 C and walk down one degree per cycle.
    // At most 168 steps, far shorter than a conversion period.
    wire [1:0] seg = seg_of(step_temp_r, bp_low_r, bp_mid_r, bp_high_r);
    wire [8:0] temp_ext = {temp_deg[7], temp_deg};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= `ST_IDLE;
            step_temp_r <= `MODEL_TOP_TEMP;
            target_r <= `MODEL_TOP_TEMP;
            full_v_r <= 32'h0000_0000;
            ae_v_r <= 32'h0000_0000;
            se_v_r <= 32'h0000_0000;
            start_r <= 1'b1;
            full_capacity <= 16'h0000;
            active_empty_capacity <= 16'h0000;
            standby_empty_capacity <= 16'h0000;
        end else begin
            case (state_r)
                `ST_IDLE: begin
                    if (conv_strobe || (start_r && load_done_r)) begin
                        start_r <= 1'b0;
                        step_temp_r <= `MODEL_TOP_TEMP; // [R13]
                        // Above 40 C the walk stops at 40 C
                        if ($signed(temp_ext) > $signed(`MODEL_TOP_TEMP)) begin
                            target_r <= `MODEL_TOP_TEMP; // [R7]
                        end else begin
                            target_r <= temp_ext;
                        end
                        full_v_r <= {2'b00, full40_r, 14'h0000}; // [R14]
                        ae_v_r <= {2'b00, ae_start, 6'h00}; // [R14]
                        se_v_r <= 32'h0000_0000; // [R15] [R17]
                        state_r <= `ST_STEP;
                    end
                end
                `ST_STEP: begin
                    if ($signed(step_temp_r) > $signed(target_r)) begin
                        full_v_r <= step_down(full_v_r, full40_r,
                            slope_r[{2'd0, seg}]); // [R6] [R12]
                        ae_v_r <= step_down(ae_v_r, full40_r,
                            slope_r[{2'd1, seg}]);
                        se_v_r <= step_down(se_v_r, full40_r,
                            slope_r[{2'd2, seg}]); // [R17]
                        step_temp_r <= step_temp_r - 9'h001; // [R12]
                    end else begin
                        full_capacity <= model_out(full_v_r);
                        active_empty_capacity <= model_out(ae_v_r);
                        standby_empty_capacity <= model_out(se_v_r);
                        state_r <= `ST_IDLE;
                    end
                end
                default: state_r <= `ST_IDLE;
            endcase
        end
    end

endmodule // accum_bias_blank_cell_model

// ---- src/accum_model_defs.vh ----
`ifndef ACCUM_MODEL_DEFS_VH
`define ACCUM_MODEL_DEFS_VH

// Register indexes; byte address is four times the index
`define IDX_CONTROL 8'h60
`define IDX_TRIM 8'h61
`define IDX_ACCUM_OFS 8'h62
`define IDX_ACCUM 8'h63
`define IDX_CURRENT 8'h64
`define IDX_FULL_CAP 8'h65
`define IDX_AE_CAP 8'h66
`define IDX_SE_CAP 8'h67
`define IDX_FULL40 8'h68
`define IDX_AE_FRAC 8'h69
`define IDX_SLOPE_FIRST 8'h6b
`define IDX_FULL_SEG3_SLOPE 8'h6d
`define IDX_SLOPE_LAST 8'h76
`define IDX_BP_LOW 8'h7c
`define IDX_BP_MID 8'h7d
`define IDX_BP_HIGH 8'h7e

// Control register field
`define CTRL_NEG_BLANK_BIT 0

// Blanking limits in current counts of 1.5625 uV
`define CHG_BLANK_LIMIT 16'h0040
`define DIS_BLANK_LIMIT 16'h0010

// Conversion timebase
`define CONV_PERIOD_US 3515000
`define CLK_MHZ 200

// Accumulator: 16 integer bits over 12 fraction bits
`define ACCUM_W 28
`define ACCUM_FRAC_W 12
`define ACCUM_MAX 28'h7ffffff
`define ACCUM_MIN 28'h8000000

// Cell model
`define MODEL_TOP_TEMP 9'h028
`define SLOPE_SHIFT 14
`define AE_FRAC_SHIFT 6
`define NUM_SLOPES 12
`define SLOPE_IDX_W 4

// State codes, one-hot
`define ST_IDLE 2'b01
`define ST_STEP 2'b10

`endif
